// ===== core/als_params.svh
`ifndef ALS_PARAMS_SVH
`define ALS_PARAMS_SVH
// ****************************************
// device configuration addresses
// ****************************************
`define ALS_A_LINK   4'h0
`define ALS_A_CAL    4'h1
`define ALS_A_FMT    4'h2
`define ALS_A_KM1    4'h3
`define ALS_A_SYNC   4'h4
`define ALS_A_CALOPT 4'h5
`define ALS_A_OVR    4'h6
`define ALS_A_OVRTH  4'h7
`define ALS_A_TRIG   4'h8
`define ALS_A_SRCHK  4'h9
`define ALS_A_STAT   4'hA
// device status bits
`define ALS_ST_SR_OK   0
`define ALS_ST_CALBSY  1
`define ALS_ST_CALDONE 2
`define ALS_ST_LINKUP  3
// ****************************************
// controller register map
// ****************************************
`define ALS_O_CTRL 12'h000
`define ALS_O_CFG  12'h004
`define ALS_O_STAT 12'h008
`define ALS_F_FMT   4:0
`define ALS_F_KM1   12:8
`define ALS_F_SYNC  16
`define ALS_F_CALOP 18:17
`define ALS_F_OVR   19
`define ALS_F_OVRTH 31:24
`define ALS_RST_CFG 32'h0000_0700
`define ALS_RST_KM1 5'h07
// ****************************************
// timing
// ****************************************
`define ALS_CLK_NS      8
`define ALS_RST_NS      1000
`define ALS_RST_CYC     ((`ALS_RST_NS + `ALS_CLK_NS - 1) / `ALS_CLK_NS)
`define ALS_SETTLE_NS   2000
`define ALS_SETTLE_CYC  ((`ALS_SETTLE_NS + `ALS_CLK_NS - 1) / `ALS_CLK_NS)
`define ALS_CAL_CYC     7'h40
`define ALS_SR_EDGES    3'h4
`define ALS_ILAS_MF     3'h4
`define ALS_POLL_MAX    16'h0FA0
`endif

// ===== core/als_pkg.sv
`default_nettype none
package als_pkg;
    typedef enum logic [2:0] {L_HALT, L_WAIT, L_CGS, L_ILAS, L_DATA} als_link_e;
    typedef enum logic [1:0] {C_HALT, C_IDLE, C_RUN} als_cal_e;
    typedef enum logic [4:0] {
        H_IDLE, H_RESET, H_CLKWAIT, H_LINK_OFF, H_CAL_OFF, H_FMT, H_KM1,
        H_SYNC, H_CALOPT, H_CAL_ON, H_OVR, H_OVRTH, H_SR_ON, H_SR_CHK,
        H_SR_POLL, H_LINK_ON, H_TRIG0, H_TRIG1, H_DONE, H_ERR
    } als_host_e;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic       link_run;
        logic       cal_run;
        logic [4:0] fmt;
        logic [4:0] km1;
        logic       sync_src;
        logic [1:0] cal_opt;
        logic       overrange_enable;
        logic [7:0] ovr_th;
        logic       trig;
        logic       sr_chk;
        logic [2:0] sr_cnt;
        logic       sysref_q;
        logic       sr_ok;
        als_link_e  link;
        logic [7:0] ilas_cnt;
        als_cal_e   cal;
        logic [6:0] cal_cnt;
        logic       cal_done;
        logic       ovr;
    } als_dev_s;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] prdata;
        logic        done;
        logic        err;
        als_host_e   st;
        logic [15:0] cnt;
        logic [15:0] polls;
        logic        req;
        logic        we;
        logic [3:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  dstat;
        logic        dev_rst_n;
        logic        sr_cont;
    } als_host_s;
endpackage : als_pkg
`default_nettype wire

// ===== core/als_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface als_cfg_if (input wire logic pclk, input wire logic presetn);
    logic       dev_rst_n;
    logic       req;
    logic       we;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport dev  (input dev_rst_n, req, we, addr, wdata, output ack, rdata);
    modport host (output dev_rst_n, req, we, addr, wdata, input ack, rdata);
endinterface : als_cfg_if
`default_nettype wire

// ===== core/als_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "als_params.svh"
module als_dev_end import als_pkg::*; (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // configuration port
    als_cfg_if.dev          cfg,
    // link pins
    input  wire logic       sysref,
    input  wire logic       sync_se_n,
    input  wire logic       sync_ts_n,
    // sample path
    input  wire logic [7:0] sample_mag,
    // status
    output als_link_e       link_state,
    output logic            cal_busy,
    output logic            ovr_flag,
    output logic [4:0]      lane_fmt,
    output logic [4:0]      km1
);
    als_dev_s r;
    als_dev_s n;
    logic     sync_n;
    logic     wr;
    logic     sr_rise;

    always_comb
    begin
        n       = r;
        wr      = cfg.req & ~r.ack & cfg.we;
        sr_rise = sysref & ~r.sysref_q;
        n.sysref_q = sysref;
        // ****************************************
        // configuration access
        // ****************************************
        n.ack = cfg.req & ~r.ack;
        if (cfg.req & ~r.ack)
        begin
            n.rdata = {4'h0, r.link == L_DATA, r.cal_done, r.cal == C_RUN, r.sr_ok};
        end
        if (wr)
        begin
            case (cfg.addr)
                `ALS_A_LINK:   n.link_run = cfg.wdata[0];
                `ALS_A_CAL:    n.cal_run  = cfg.wdata[0];
                `ALS_A_FMT:    n.fmt      = cfg.wdata[4:0];
                // holds frames per multiframe less one
                `ALS_A_KM1:    n.km1      = cfg.wdata[4:0];
                `ALS_A_SYNC:   n.sync_src = cfg.wdata[0];
                `ALS_A_CALOPT: n.cal_opt  = cfg.wdata[1:0];
                `ALS_A_OVR:    n.overrange_enable   = cfg.wdata[0];
                `ALS_A_OVRTH:  n.ovr_th   = cfg.wdata;
                `ALS_A_TRIG:   n.trig     = cfg.wdata[0];
                `ALS_A_SRCHK:
                begin
                    n.sr_chk = cfg.wdata[0];
                    n.sr_ok  = 1'b0;
                    n.sr_cnt = 3'h0;
                end
                default: ;
            endcase
        end
        // sysref timing check counts clean edges
        if (r.sr_chk & sr_rise & ~r.sr_ok)
        begin
            n.sr_cnt = r.sr_cnt + 3'h1;
            if (r.sr_cnt == `ALS_SR_EDGES - 3'h1)
            begin
                n.sr_ok = 1'b1;
            end
        end
        // ****************************************
        // link state machine
        // ****************************************
        // choose sync request source
        sync_n = r.sync_src ? sync_ts_n : sync_se_n;
        if (!r.link_run)
        begin
            n.link = L_HALT;
        end
        else
        begin
            case (r.link)
                L_HALT: n.link = L_WAIT;
                L_WAIT: if (r.sr_ok && !sync_n) n.link = L_CGS;
                L_CGS:
                begin
                    n.ilas_cnt = 8'h00;
                    if (sync_n) n.link = L_ILAS;
                end
                L_ILAS:
                begin
                    n.ilas_cnt = r.ilas_cnt + 8'h01;
                    if (!sync_n) n.link = L_CGS;
                    else if (r.ilas_cnt == {1'b0, r.km1, 2'b11}) n.link = L_DATA;
                end
                L_DATA: if (!sync_n) n.link = L_CGS;
                default: n.link = L_HALT;
            endcase
        end
        // ****************************************
        // calibration state machine
        // ****************************************
        if (!r.cal_run)
        begin
            n.cal = C_HALT;
        end
        else
        begin
            case (r.cal)
                C_HALT: n.cal = C_RUN;
                C_IDLE:
                begin
                    if (wr && cfg.addr == `ALS_A_TRIG && cfg.wdata[0] && !r.trig)
                    begin
                        n.cal = C_RUN;
                    end
                end
                C_RUN:
                begin
                    n.cal_cnt = r.cal_cnt + 7'h01;
                    if (r.cal_cnt == `ALS_CAL_CYC - 7'h01)
                    begin
                        n.cal      = C_IDLE;
                        n.cal_done = 1'b1;
                    end
                end
                default: n.cal = C_HALT;
            endcase
        end
        if (n.cal == C_RUN && r.cal != C_RUN)
        begin
            n.cal_cnt  = 7'h00;
            n.cal_done = 1'b0;
        end
        n.ovr = r.overrange_enable & (sample_mag >= r.ovr_th);
        // soft reset from the controller clears all settings except km1, which takes its reset value
        if (!cfg.dev_rst_n)
        begin
            n = '0;
            n.km1 = `ALS_RST_KM1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r     <= '0;
            r.km1 <= `ALS_RST_KM1;
        end
        else
        begin
            r <= n;
        end
    end

    assign cfg.ack    = r.ack;
    assign cfg.rdata  = r.rdata;
    assign link_state = r.link;
    assign cal_busy   = (r.cal == C_RUN);
    assign ovr_flag   = r.ovr;
    assign lane_fmt   = r.fmt;
    assign km1        = r.km1;
endmodule : als_dev_end
`default_nettype wire

// ===== core/als_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "als_params.svh"
module als_host_end import als_pkg::*; (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // system
    input  wire logic        clk_stable,
    output logic             sysref_cont_en,
    output logic             busy,
    // device configuration port
    als_cfg_if.host          cfg
);
    als_host_s r;
    als_host_s n;
    logic      setup;
    logic      access;
    logic      mapped;
    logic      running;
    logic      start;
    logic [11:0] wv;

    // address and data of a step's device write
    function automatic logic [11:0] step_write(input als_host_e s, input logic [31:0] c);
        logic [11:0] v;
        v = 12'h000;
        case (s)
            H_LINK_OFF: v = {`ALS_A_LINK, 8'h00};
            H_CAL_OFF:  v = {`ALS_A_CAL, 8'h00};
            H_FMT:      v = {`ALS_A_FMT, 3'h0, c[`ALS_F_FMT]};
            H_KM1:      v = {`ALS_A_KM1, 3'h0, c[`ALS_F_KM1]};
            H_SYNC:     v = {`ALS_A_SYNC, 7'h00, c[`ALS_F_SYNC]};
            H_CALOPT:   v = {`ALS_A_CALOPT, 6'h00, c[`ALS_F_CALOP]};
            H_CAL_ON:   v = {`ALS_A_CAL, 8'h01};
            H_OVR:      v = {`ALS_A_OVR, 7'h00, c[`ALS_F_OVR]};
            H_OVRTH:    v = {`ALS_A_OVRTH, c[`ALS_F_OVRTH]};
            H_SR_CHK:   v = {`ALS_A_SRCHK, 8'h01};
            H_LINK_ON:  v = {`ALS_A_LINK, 8'h01};
            H_TRIG0:    v = {`ALS_A_TRIG, 8'h00};
            H_TRIG1:    v = {`ALS_A_TRIG, 8'h01};
            default:    v = 12'h000;
        endcase
        return v;
    endfunction : step_write

    // fixed order of the start-up walk
    function automatic als_host_e next_step(input als_host_e s);
        als_host_e t;
        t = H_IDLE;
        case (s)
            H_LINK_OFF: t = H_CAL_OFF;
            H_CAL_OFF:  t = H_FMT;
            H_FMT:      t = H_KM1;
            H_KM1:      t = H_SYNC;
            H_SYNC:     t = H_CALOPT;
            H_CALOPT:   t = H_CAL_ON;
            H_CAL_ON:   t = H_OVR;
            H_OVR:      t = H_OVRTH;
            H_OVRTH:    t = H_SR_ON;
            H_SR_CHK:   t = H_SR_POLL;
            H_LINK_ON:  t = H_TRIG0;
            H_TRIG0:    t = H_TRIG1;
            H_TRIG1:    t = H_DONE;
            default:    t = H_IDLE;
        endcase
        return t;
    endfunction : next_step

    function automatic logic is_write_step(input als_host_e s);
        logic w;
        w = 1'b0;
        case (s)
            H_LINK_OFF, H_CAL_OFF, H_FMT, H_KM1, H_SYNC, H_CALOPT,
            H_CAL_ON, H_OVR, H_OVRTH, H_SR_CHK, H_LINK_ON,
            H_TRIG0, H_TRIG1: w = 1'b1;
            default: w = 1'b0;
        endcase
        return w;
    endfunction : is_write_step

    always_comb
    begin
        n       = r;
        setup   = psel & ~penable;
        access  = psel & penable;
        mapped  = (paddr == `ALS_O_CTRL) || (paddr == `ALS_O_CFG)
                  || (paddr == `ALS_O_STAT);
        running = (r.st != H_IDLE) && (r.st != H_DONE) && (r.st != H_ERR);
        start   = access & pwrite & (paddr == `ALS_O_CTRL) & pwdata[0] & ~running;
        wv      = step_write(r.st, r.cfg);
        // ****************************************
        // apb registers
        // ****************************************
        if (setup)
        begin
            case (paddr)
                `ALS_O_CTRL: n.prdata = {31'h0, running};
                `ALS_O_CFG:  n.prdata = r.cfg;
                `ALS_O_STAT: n.prdata = {8'h00, r.dstat, 3'h0, r.st, 5'h00,
                                         r.err, r.done, running};
                default:     n.prdata = 32'h0000_0000;
            endcase
        end
        // settings frozen while a walk runs
        if (access && pwrite && paddr == `ALS_O_CFG && !running)
        begin
            n.cfg = pwdata;
        end
        if (start)
        begin
            n.done = 1'b0;
            n.err  = 1'b0;
            n.st   = H_RESET;
            n.cnt  = 16'h0000;
        end
        // ****************************************
        // start-up walk
        // ****************************************
        case (r.st)
            H_IDLE, H_DONE, H_ERR: ;
            H_RESET:
            begin
                n.dev_rst_n = 1'b0;
                n.sr_cont   = 1'b0;
                n.cnt       = r.cnt + 16'h0001;
                if (r.cnt == 16'(`ALS_RST_CYC - 1))
                begin
                    n.dev_rst_n = 1'b1;
                    n.st        = H_CLKWAIT;
                end
            end
            // no writes before clock is stable
            H_CLKWAIT: if (clk_stable) n.st = H_LINK_OFF;
            H_SR_ON:
            begin
                n.sr_cont = 1'b1;
                n.cnt     = r.cnt + 16'h0001;
                if (r.cnt == 16'(`ALS_SETTLE_CYC - 1))
                begin
                    n.st = H_SR_CHK;
                end
            end
            H_SR_POLL:
            begin
                if (!r.req)
                begin
                    n.req  = 1'b1;
                    n.we   = 1'b0;
                    n.addr = `ALS_A_STAT;
                end
                else if (cfg.ack)
                begin
                    n.req   = 1'b0;
                    n.dstat = cfg.rdata;
                    n.polls = r.polls + 16'h0001;
                    if (cfg.rdata[`ALS_ST_SR_OK])
                    begin
                        n.st = H_LINK_ON;
                    end
                    else if (r.polls == `ALS_POLL_MAX - 16'h0001)
                    begin
                        n.st = H_ERR;
                    end
                end
            end
            default:
            begin
                if (is_write_step(r.st))
                begin
                    if (!r.req)
                    begin
                        n.req   = 1'b1;
                        n.we    = 1'b1;
                        n.addr  = wv[11:8];
                        n.wdata = wv[7:0];
                    end
                    else if (cfg.ack)
                    begin
                        n.req = 1'b0;
                        n.st  = next_step(r.st);
                    end
                end
                else
                begin
                    n.st = H_IDLE;
                end
            end
        endcase
        if (r.st == H_SR_ON || r.st == H_RESET)
        begin
            n.polls = 16'h0000;
        end
        if (next_step(r.st) == H_DONE && r.req && cfg.ack)
        begin
            n.done = 1'b1;
        end
        if (r.st == H_SR_POLL && n.st == H_ERR)
        begin
            n.err = 1'b1;
        end
        if (r.st != n.st)
        begin
            n.cnt = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r           <= '0;
            r.cfg       <= `ALS_RST_CFG;
            r.dev_rst_n <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // zero wait states: read data is captured in the setup cycle
    assign prdata         = r.prdata;
    assign pready         = 1'b1;
    assign pslverr        = psel & penable & ~mapped;
    assign sysref_cont_en = r.sr_cont;
    assign busy           = (r.st != H_IDLE) && (r.st != H_DONE) && (r.st != H_ERR);
    assign cfg.dev_rst_n  = r.dev_rst_n;
    assign cfg.req        = r.req;
    assign cfg.we         = r.we;
    assign cfg.addr       = r.addr;
    assign cfg.wdata      = r.wdata;
endmodule : als_host_end
`default_nettype wire

// ===== tb/als_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "als_params.svh"
module als_link_asserts (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // configuration port
    input wire logic       dev_rst_n,
    input wire logic       req,
    input wire logic       we,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    // ****************************************
    // write order tracking
    // ****************************************
    logic       wr;
    logic [3:0] n_r;
    logic       link_on_r;
    logic       sr_ok_r;
    logic       trig0_r;
    assign wr = req && ack && we;

    // order restarts with every device reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn || !dev_rst_n)
        begin
            n_r       <= 4'h0;
            link_on_r <= 1'b0;
            sr_ok_r   <= 1'b0;
            trig0_r   <= 1'b0;
        end
        else
        begin
            if (wr && n_r != 4'hF)
                n_r <= n_r + 4'h1;
            if (wr && addr == `ALS_A_LINK)
                link_on_r <= wdata[0];
            if (wr && addr == `ALS_A_SRCHK)
                sr_ok_r <= 1'b0;
            else if (req && ack && !we && addr == `ALS_A_STAT && rdata[`ALS_ST_SR_OK])
                sr_ok_r <= 1'b1;
            if (wr)
                trig0_r <= (addr == `ALS_A_TRIG) && !wdata[0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_at(logic [3:0] a);
        wr && addr == a;
    endsequence
    sequence s_wr(logic [3:0] a, logic d);
        wr && addr == a && wdata[0] == d;
    endsequence
    sequence s_ack_drop;
        ack ##1 (!ack && !req);
    endsequence
    property p_nth(int k, logic [3:0] a);
        wr && n_r == k |-> s_at(a);
    endproperty

    a_first_link_off: assert property (wr && n_r == 0 |-> s_wr(`ALS_A_LINK, 1'b0))
        else $error("first write is not link halt");
    a_cal_off_second: assert property (wr && n_r == 1 |-> s_wr(`ALS_A_CAL, 1'b0))
        else $error("second write is not calib halt");
    a_fmt_third: assert property (p_nth(2, `ALS_A_FMT))
        else $error("third write is not lane format");
    a_km1_fourth: assert property (p_nth(3, `ALS_A_KM1))
        else $error("fourth write is not multiframe length");
    a_sync_fifth: assert property (p_nth(4, `ALS_A_SYNC))
        else $error("fifth write is not sync source");
    a_opts_sixth: assert property (p_nth(5, `ALS_A_CALOPT))
        else $error("sixth write is not calib options");
    a_cal_on_seventh: assert property (wr && n_r == 6 |-> s_wr(`ALS_A_CAL, 1'b1))
        else $error("seventh write is not calib enable");
    a_ovr_eighth: assert property (p_nth(7, `ALS_A_OVR))
        else $error("eighth write is not overrange enable");
    a_link_after_check: assert property (s_wr(`ALS_A_LINK, 1'b1) |-> sr_ok_r)
        else $error("link enabled before sysref confirmed");
    a_trig_pair: assert property (s_wr(`ALS_A_TRIG, 1'b1) |-> trig0_r)
        else $error("trigger one not preceded by zero");
    a_cfg_when_halted: assert property (
        wr && addr inside {`ALS_A_FMT, `ALS_A_KM1, `ALS_A_SYNC} |-> !link_on_r)
        else $error("link setting changed while link runs");
    a_rst_no_req: assert property (!dev_rst_n |-> !req)
        else $error("request during device reset");
    a_ack_one_late: assert property ($rose(req) |=> s_ack_drop)
        else $error("ack not one cycle after request");
endmodule : als_link_asserts
`default_nettype wire

// ===== tb/adc_link_startup_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "als_params.svh"
module adc_link_startup_sequencer_tb import als_pkg::*; ;
    typedef struct packed {logic [31:0] cfg; logic [7:0] mag; logic ovr;} als_row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        clk_stable, sysref_cont_en, busy, cal_busy, ovr_flag, sr_run;
    logic        sysref = 1'b0;
    logic        sync_se_n, sync_ts_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  sample_mag;
    logic [4:0]  lane_fmt, km1;
    logic [3:0]  sr_cnt = 4'h0;
    als_link_e   link_state;
    int          num_errors, checks, i, n;
    int          n_req = 0;
    als_row_s    rows [3] = '{'{32'h4008_0301, 8'h40, 1'b1},
                              '{32'h800F_1F1E, 8'h7F, 1'b0},
                              '{32'hFF01_0000, 8'hFF, 1'b0}};

    als_cfg_if cfg_bus (.pclk(pclk), .presetn(presetn));
    als_host_end als_host_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_stable(clk_stable),
        .sysref_cont_en(sysref_cont_en), .busy(busy), .cfg(cfg_bus));
    als_dev_end als_dev_end_inst (.pclk(pclk), .presetn(presetn), .cfg(cfg_bus),
        .sysref(sysref), .sync_se_n(sync_se_n), .sync_ts_n(sync_ts_n),
        .sample_mag(sample_mag), .link_state(link_state), .cal_busy(cal_busy),
        .ovr_flag(ovr_flag), .lane_fmt(lane_fmt), .km1(km1));
    als_link_asserts als_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .dev_rst_n(cfg_bus.dev_rst_n), .req(cfg_bus.req), .we(cfg_bus.we),
        .addr(cfg_bus.addr), .wdata(cfg_bus.wdata), .ack(cfg_bus.ack),
        .rdata(cfg_bus.rdata));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        sr_cnt <= sr_cnt + 4'h1;
        sysref <= sysref_cont_en && sr_run && sr_cnt[3];
        if (cfg_bus.req && cfg_bus.ack)
            n_req <= n_req + 1;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task final_report;
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            num_errors++;
            final_report;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < lim)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= lim)
        begin
            num_errors++;
            final_report;
        end
    endtask : wait_idle

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {clk_stable, sr_run, sync_se_n, sync_ts_n} = 4'hF;
        sample_mag = 8'h00;
        num_errors = 0;
        checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `ALS_O_CFG, 32'h0);
        chk("cfg_rst", rd, `ALS_RST_CFG);
        chk("km1_rst", km1, `ALS_RST_KM1);
        apb(1'b0, `ALS_O_STAT, 32'h0);
        chk("stat_rst", rd, 32'h0);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        chk("bad_werr", er, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("bad_rerr", er, 32'h1);
        chk("bad_rd", rd, 32'h0);
        // walk must wait for a stable clock
        clk_stable <= 1'b0;
        apb(1'b1, `ALS_O_CTRL, 32'h1);
        repeat (300) @(posedge pclk);
        chk("hold_busy", busy, 32'h1);
        chk("hold_reqs", n_req, 32'h0);
        apb(1'b1, `ALS_O_CFG, 32'h5);
        apb(1'b0, `ALS_O_CFG, 32'h0);
        chk("cfg_locked", rd, `ALS_RST_CFG);
        clk_stable <= 1'b1;
        wait_idle(20000);
        for (i = 0; i < 3; i++)
        begin
            apb(1'b1, `ALS_O_CFG, rows[i].cfg);
            apb(1'b0, `ALS_O_CFG, 32'h0);
            chk("cfg_rb", rd, rows[i].cfg);
            apb(1'b1, `ALS_O_CTRL, 32'h1);
            wait_idle(20000);
            chk("sr_on", sysref_cont_en, 32'h1);
            chk("cal_trig", cal_busy, 32'h1);
            apb(1'b0, `ALS_O_STAT, 32'h0);
            chk("stat_done", rd[2:0], 32'h2);
            chk("stat_step", rd[12:8], H_DONE);
            chk("stat_dev", rd[23:16], 32'h5);
            chk("fmt", lane_fmt, rows[i].cfg[4:0]);
            chk("km1", km1, rows[i].cfg[12:8]);
            sample_mag <= rows[i].mag;
            repeat (3) @(posedge pclk);
            chk("ovr", ovr_flag, rows[i].ovr);
            if (rows[i].cfg[16])
                sync_se_n <= 1'b0;
            else
                sync_ts_n <= 1'b0;
            repeat (4) @(posedge pclk);
            chk("sync_other", link_state, L_WAIT);
            {sync_se_n, sync_ts_n} <= 2'b00;
            repeat (4) @(posedge pclk);
            chk("cgs", link_state, L_CGS);
            {sync_se_n, sync_ts_n} <= 2'b11;
            repeat (2) @(posedge pclk);
            chk("ilas", link_state, L_ILAS);
            n = 2;
            while (link_state !== L_DATA && n < 300)
            begin
                @(posedge pclk);
                n++;
            end
            chk("ilas_len", n >= 4 * (rows[i].cfg[12:8] + 1) && n <= 4 * (rows[i].cfg[12:8] + 2),
                32'h1);
            repeat (70) @(posedge pclk);
            chk("cal_end", cal_busy, 32'h0);
            sample_mag <= 8'h00;
        end
        // no sysref: the timing check must give up
        sr_run <= 1'b0;
        apb(1'b1, `ALS_O_CTRL, 32'h1);
        wait_idle(40000);
        apb(1'b0, `ALS_O_STAT, 32'h0);
        chk("stat_err", rd[2:0], 32'h4);
        chk("stat_eds", rd[23:16], 32'h4);
        chk("link_held", link_state, L_HALT);
        // reset in mid-walk must return all to idle
        apb(1'b1, `ALS_O_CTRL, 32'h1);
        repeat (200) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("rst_busy", busy, 32'h0);
        chk("rst_sr", sysref_cont_en, 32'h0);
        chk("rst_km1", km1, `ALS_RST_KM1);
        chk("rst_cal", cal_busy, 32'h0);
        chk("rst_link", link_state, L_HALT);
        apb(1'b0, `ALS_O_CFG, 32'h0);
        chk("rst_cfg", rd, `ALS_RST_CFG);
        final_report;
    end
endmodule : adc_link_startup_sequencer_tb
`default_nettype wire
